//--- pkg/sap_pkg.sv
// shared constants and types of the stereo serial output port
package sap_pkg;

    // sample word and frame layout
    localparam int unsigned SAMPLE_W       = 24;
    localparam int unsigned SLOT_BITS      = 32;
    localparam int unsigned FRAME_BITS     = 64;         // bit clock is 64 x output_sample_rate
    localparam int unsigned BIT_IDX_W      = 6;
    localparam int unsigned FIFO_DEPTH     = 4;

    // system clock rate and derived timing
    localparam int unsigned CLK_KHZ        = 40000;      // 40 MHz, 25 ns period
    localparam int unsigned OVR_TMO_441_MS = 740;        // 44.1/88.2/176.4 kHz family
    localparam int unsigned OVR_TMO_48_MS  = 680;        // 48/96/192 kHz family
    localparam int unsigned OVR_CYC_441    = OVR_TMO_441_MS * CLK_KHZ;
    localparam int unsigned OVR_CYC_48     = OVR_TMO_48_MS * CLK_KHZ;
    localparam int unsigned OVR_CNT_W      = 25;

    // overflow pin update point, in bit-clock periods after a frame edge
    localparam logic [5:0]  OVF_DLY_LJ     = 6'h01;
    localparam logic [5:0]  OVF_DLY_I2S    = 6'h02;
    localparam int unsigned OVF_SETUP_BCLK = 16;
    localparam int unsigned OVF_HOLD_BCLK  = 1;

    // speed mode codes on {speed_mode_sel_hi, speed_mode_sel_lo}
    localparam logic [1:0]  SPD_SINGLE     = 2'h0;
    localparam logic [1:0]  SPD_DOUBLE     = 2'h1;
    localparam logic [1:0]  SPD_QUAD       = 2'h2;
    localparam logic [1:0]  SPD_RESERVED   = 2'h3;

    // allowed output_sample_rate ranges, kHz
    localparam int unsigned FS_SINGLE_MIN  = 2;
    localparam int unsigned FS_SINGLE_MAX  = 51;
    localparam int unsigned FS_DOUBLE_MIN  = 50;
    localparam int unsigned FS_DOUBLE_MAX  = 102;
    localparam int unsigned FS_QUAD_MIN    = 100;
    localparam int unsigned FS_QUAD_MAX    = 204;

    // master bit clock half period in divided master clock ticks
    // (256x single speed -> /4, 128x double and quad -> /2)
    localparam logic [1:0]  BCLK_HALF_SINGLE = 2'h2;
    localparam logic [1:0]  BCLK_HALF_FAST   = 2'h1;

    // offset filter time constant, 2^HPF_SHIFT samples
    localparam int unsigned HPF_SHIFT      = 10;

    // serializer states
    typedef enum logic {
        SAP_WAIT,
        SAP_SHIFT
    } sap_state_t;

endpackage

//--- pkg/sap_stream_if.sv
// valid/ready stream carrying sample pairs into and out of the fifo
`timescale 1ns/1ps
interface sap_stream_if #(
    parameter int unsigned W = 48
);
    logic [W-1:0] wdata;
    logic         wvalid;
    logic         wready;
    logic [W-1:0] rdata;
    logic         rvalid;
    logic         rready;

    modport fifo (
        input  wdata,
        input  wvalid,
        output wready,
        output rdata,
        output rvalid,
        input  rready
    );

    modport user (
        output wdata,
        output wvalid,
        input  wready,
        input  rdata,
        input  rvalid,
        output rready
    );
endinterface

//--- logic/sap_fifo.sv
// small synchronous fifo for sample pairs
`timescale 1ns/1ps
module sap_fifo #(
    parameter int unsigned W     = 48,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    sap_stream_if.fifo s
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;

    wire do_wr = s.wvalid && s.wready;
    wire do_rd = s.rvalid && s.rready;

    // honest flags straight from the occupancy count
    assign s.wready = (count != CW'(DEPTH));
    assign s.rvalid = (count != '0);
    assign s.rdata  = mem[rd_ptr];

    // storage has no reset, only valid words are ever read
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr] <= s.wdata;
        end
    end

    // pointers wrap at DEPTH so non power of two depths work too
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + CW'(do_wr) - CW'(do_rd);
        end
    end
endmodule

//--- logic/sap_port.sv
// serial sample output port with clock generation, offset filter and overflow pin
`timescale 1ns/1ps
module sap_port #(
    parameter int unsigned OVR_TIMEOUT_441 = sap_pkg::OVR_CYC_441,
    parameter int unsigned OVR_TIMEOUT_48  = sap_pkg::OVR_CYC_48,
    parameter int unsigned DEPTH           = sap_pkg::FIFO_DEPTH
) (
    input  wire logic                         clk_sys,
    input  wire logic                         rst_n,
    input  wire logic                         clock_master_sel,
    input  wire logic                         master_clock_halve,
    input  wire logic                         offset_filter_enable,
    input  wire logic                         frame_format_select,
    input  wire logic                         speed_mode_sel_lo,
    input  wire logic                         speed_mode_sel_hi,
    input  wire logic                         rate_family_48k,
    input  wire logic [sap_pkg::SAMPLE_W-1:0] sample_left,
    input  wire logic [sap_pkg::SAMPLE_W-1:0] sample_right,
    input  wire logic                         sample_valid,
    output logic                              sample_ready,
    input  wire logic                         overrange_left,
    input  wire logic                         overrange_right,
    input  wire logic                         channel_frame_clock_in,
    output logic                              channel_frame_clock_out,
    output logic                              channel_frame_clock_oe,
    input  wire logic                         bit_clock_in,
    output logic                              bit_clock_out,
    output logic                              bit_clock_oe,
    output logic                              serial_sample_out,
    output logic                              overflow_out,
    output logic                              overflow_oe
);
    import sap_pkg::*;

    localparam int unsigned SW = SAMPLE_W;
    localparam int unsigned AW = SAMPLE_W + HPF_SHIFT;
    localparam int unsigned NS = 9;

    // ---------------- pin synchronisers ----------------
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    wire  [NS-1:0] pins_raw = {clock_master_sel, master_clock_halve, offset_filter_enable,
                               frame_format_select, speed_mode_sel_lo, speed_mode_sel_hi,
                               rate_family_48k, channel_frame_clock_in, bit_clock_in};

    // the nine control and clock pins pass two flops; only sync2 is read by logic
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pins_raw[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    wire       is_master  = sync2[8];
    wire       halve      = sync2[7];
    wire       hpf_track  = sync2[6];
    wire       fmt_i2s    = sync2[5];
    wire [1:0] speed      = {sync2[3], sync2[4]};
    wire       fam_48     = sync2[2];
    wire       channel_frame_clock_pin   = sync2[1];
    wire       bclk_pin   = sync2[0];

    // a reserved mode code parks the port rather than guessing a rate
    wire       mode_ok    = (speed != SPD_RESERVED);
    wire [1:0] bclk_half  = (speed == SPD_SINGLE) ? BCLK_HALF_SINGLE : BCLK_HALF_FAST;

    // ---------------- master clock generation ----------------
    logic           div_phase;
    logic [1:0]     half_cnt;
    logic           m_bclk;
    logic [5:0]     m_bit_cnt;
    logic           m_channel_frame_clock;

    // halving the master clock means every second system edge counts
    wire tick        = halve ? div_phase : 1'b1;
    wire half_done   = tick && (half_cnt == bclk_half - 2'h1);
    wire m_fall      = half_done && m_bclk;
    wire [5:0] next_m_bit_cnt = m_bit_cnt + 6'h01;
    // left slot is high in left-justified, low in I2S
    wire next_m_channel_frame_clock = ~next_m_bit_cnt[5] ^ fmt_i2s;

    // bit clock is 64 x frame clock, both derived from clk_sys
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_phase <= 1'b0;
            half_cnt  <= 2'h0;
            m_bclk    <= 1'b0;
            m_bit_cnt <= 6'h3f;
            m_channel_frame_clock    <= 1'b0;
        end else if (!is_master || !mode_ok) begin
            div_phase <= 1'b0;
            half_cnt  <= 2'h0;
            m_bclk    <= 1'b0;
            m_bit_cnt <= 6'h3f;
            m_channel_frame_clock    <= fmt_i2s;
        end else begin
            div_phase <= ~div_phase;
            if (tick) begin
                half_cnt <= half_done ? 2'h0 : half_cnt + 2'h1;
            end
            if (half_done) begin
                m_bclk <= ~m_bclk;
            end
            if (m_fall) begin
                m_bit_cnt <= next_m_bit_cnt;
                m_channel_frame_clock    <= next_m_channel_frame_clock;
            end
        end
    end

    // clock pins driven only as master in a legal mode
    assign bit_clock_out           = m_bclk;
    assign channel_frame_clock_out = m_channel_frame_clock;
    assign bit_clock_oe            = is_master && mode_ok;
    assign channel_frame_clock_oe  = is_master && mode_ok;

    // ---------------- common edge view ----------------
    wire  bclk_lvl = is_master ? m_bclk : bclk_pin;
    wire  channel_frame_clock_lvl = is_master ? m_channel_frame_clock : channel_frame_clock_pin;
    logic bclk_prev;
    logic channel_frame_clock_at_fall;

    wire  fall       = bclk_prev && !bclk_lvl;
    wire  frame_edge = fall && (channel_frame_clock_lvl != channel_frame_clock_at_fall);
    // frame clock high is left in left-justified, low is left in I2S
    wire  new_left   = channel_frame_clock_lvl ^ fmt_i2s;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bclk_prev    <= 1'b0;
            channel_frame_clock_at_fall <= 1'b0;
        end else begin
            bclk_prev <= bclk_lvl;
            if (fall) begin
                channel_frame_clock_at_fall <= channel_frame_clock_lvl;
            end
        end
    end

    // ---------------- offset filter ----------------
    wire  [SW-1:0] sample_in [2];
    logic [SW-1:0] filtered  [2];
    assign sample_in[0] = sample_left;
    assign sample_in[1] = sample_right;

    sap_stream_if #(.W(2 * SW)) pair_q ();
    wire accept = pair_q.wvalid && pair_q.wready;

    // the offset estimate tracks while enabled and freezes, still subtracted, when not
    generate
        for (gi = 0; gi < 2; gi++) begin : g_hpf
            logic signed [AW-1:0] acc;
            wire  signed [SW-1:0] dc   = acc[AW-1:HPF_SHIFT];
            wire  signed [SW:0]   diff = {sample_in[gi][SW-1], sample_in[gi]} - {dc[SW-1], dc};
            wire                  ovf  = diff[SW] != diff[SW-1];
            // saturate so the result stays a legal two's complement word
            assign filtered[gi] = ovf ? {diff[SW], {(SW-1){~diff[SW]}}} : diff[SW-1:0];

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    acc <= '0;
                end else if (accept && hpf_track) begin
                    acc <= acc + AW'(diff);
                end
            end
        end
    endgenerate

    assign pair_q.wdata  = {filtered[0], filtered[1]};
    assign pair_q.wvalid = sample_valid;
    assign sample_ready  = pair_q.wready;

    sap_fifo #(
        .W     (2 * SW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .s       (pair_q.fifo)
    );

    // ---------------- serializer ----------------
    sap_state_t          state;
    logic [SW-1:0]       shreg;
    logic [SW-1:0]       right_word;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic                sdo;

    // a pair is taken at the start of each left slot; empty fifo sends silence
    assign pair_q.rready = frame_edge && new_left && mode_ok;
    wire [SW-1:0] left_word = pair_q.rvalid ? pair_q.rdata[2*SW-1:SW] : '0;
    wire [SW-1:0] slot_word = new_left ? left_word : right_word;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state      <= SAP_WAIT;
            shreg      <= '0;
            right_word <= '0;
            bit_idx    <= '0;
            sdo        <= 1'b0;
        end else if (!mode_ok) begin
            state <= SAP_WAIT;
            sdo   <= 1'b0;
        end else if (frame_edge) begin
            state   <= SAP_SHIFT;
            bit_idx <= '0;
            if (new_left) begin
                right_word <= pair_q.rvalid ? pair_q.rdata[SW-1:0] : '0;
            end
            if (fmt_i2s) begin
                sdo   <= 1'b0;
                shreg <= slot_word;
            end else begin
                sdo   <= slot_word[SW-1];
                shreg <= {slot_word[SW-2:0], 1'b0};
            end
        end else if (fall && state == SAP_SHIFT) begin
            // msb first, zeros fill the rest of the 32-bit slot
            sdo     <= shreg[SW-1];
            shreg   <= {shreg[SW-2:0], 1'b0};
            bit_idx <= (bit_idx == BIT_IDX_W'(FRAME_BITS - 1)) ? bit_idx : bit_idx + 1'b1;
        end
    end

    assign serial_sample_out = sdo;

    // ---------------- overflow timeout ----------------
    logic [OVR_CNT_W-1:0] ovr_cnt;
    wire  ovr_event  = overrange_left || overrange_right;
    wire  [OVR_CNT_W-1:0] ovr_load = fam_48 ? OVR_CNT_W'(OVR_TIMEOUT_48)
                                            : OVR_CNT_W'(OVR_TIMEOUT_441);
    wire  ovr_active = (ovr_cnt != '0);

    // one shared timer, so a hit on either side keeps both flags low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ovr_cnt <= '0;
        end else if (ovr_event) begin
            ovr_cnt <= ovr_load;
        end else if (ovr_active) begin
            ovr_cnt <= ovr_cnt - 1'b1;
        end
    end

    // ---------------- overflow pin ----------------
    logic ovf_pin_low;
    wire [5:0] ovf_dly  = fmt_i2s ? OVF_DLY_I2S : OVF_DLY_LJ;
    // updating early in the slot leaves 30 or 31 bit clocks of setup and 1 or 2 bit clocks of hold
    wire ovf_update = fall && !frame_edge && state == SAP_SHIFT
                      && (BIT_IDX_W'(bit_idx + 1'b1) == BIT_IDX_W'(ovf_dly));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ovf_pin_low <= 1'b0;
        end else if (!mode_ok) begin
            ovf_pin_low <= 1'b0;
        end else if (ovf_update) begin
            ovf_pin_low <= ovr_active || ovr_event;
        end
    end

    // open drain: only ever pulls low, released otherwise
    assign overflow_out = 1'b0;
    assign overflow_oe  = ovf_pin_low;
endmodule

//--- tb/sap_port_asserts.sv
// concurrent checks on the serial sample output port pins
`timescale 1ns/1ps
module sap_port_asserts #(
    parameter int unsigned OVR_TIMEOUT_441 = 2000,
    parameter int unsigned OVR_TIMEOUT_48  = 1500
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clock_master_sel,
    input wire logic master_clock_halve,
    input wire logic speed_mode_sel_lo,
    input wire logic speed_mode_sel_hi,
    input wire logic rate_family_48k,
    input wire logic overrange_left,
    input wire logic overrange_right,
    input wire logic channel_frame_clock_out,
    input wire logic channel_frame_clock_oe,
    input wire logic bit_clock_out,
    input wire logic bit_clock_oe,
    input wire logic overflow_out,
    input wire logic overflow_oe
);
    logic [31:0] since_ovr;
    wire  [1:0]  spd  = {speed_mode_sel_hi, speed_mode_sel_lo};
    wire  [31:0] tmo  = rate_family_48k ? OVR_TIMEOUT_48 : OVR_TIMEOUT_441;
    wire         slow = bit_clock_oe && spd == 2'h0;
    wire         on   = bit_clock_out || !bit_clock_oe;
    wire         off  = !bit_clock_out || !bit_clock_oe;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // cycles since the last overrange, saturating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            since_ovr <= 32'hffffffff;
        else if (overrange_left || overrange_right)
            since_ovr <= 32'h0;
        else if (since_ovr != 32'hffffffff)
            since_ovr <= since_ovr + 32'h1;
    end

    // one high phase of the bit clock; a master switched off mid-phase is excused
    sequence s_high2;
        on [*2] ##1 off;
    endsequence
    sequence s_high4;
        on [*4] ##1 off;
    endsequence

    a_reset_quiet: assert property ($rose(rst_n) |-> !$past(bit_clock_oe)
        && !$past(channel_frame_clock_oe) && !$past(overflow_oe)) else $error("driven in reset");
    a_slave_no_drive: assert property (!clock_master_sel [*4]
        |-> !bit_clock_oe && !channel_frame_clock_oe) else $error("slave drives clocks");
    a_reserved_idle: assert property ((spd == 2'h3) [*4]
        |-> !bit_clock_oe && !overflow_oe) else $error("reserved mode not idle");
    a_ovf_open_drain: assert property (overflow_out == 1'b0)
        else $error("overflow pin driven high");
    a_bclk_single: assert property ($rose(bit_clock_out) && slow && !master_clock_halve
        |-> s_high2) else $error("bit clock phase not 2 cycles");
    a_bclk_halved: assert property ($rose(bit_clock_out) && slow && master_clock_halve
        |-> s_high4) else $error("halved bit clock phase not 4 cycles");
    a_frame_on_fall: assert property (bit_clock_oe && $rose(bit_clock_out)
        |-> $stable(channel_frame_clock_out)) else $error("frame edge on bit clock rise");
    a_ovf_report: assert property ((overrange_left || overrange_right) && bit_clock_oe
        |-> ##[1:600] overflow_oe) else $error("overrange not reported");
    a_ovf_timeout: assert property ($fell(overflow_oe) && bit_clock_oe
        |-> since_ovr >= tmo - 32'h1) else $error("overflow released early");
    a_ovf_hold_edge: assert property (slow && !master_clock_halve
        && $changed(channel_frame_clock_out) |=> $stable(overflow_oe) [*3])
        else $error("overflow changed at frame edge");
endmodule

bind sap_port sap_port_asserts #(
    .OVR_TIMEOUT_441(OVR_TIMEOUT_441),
    .OVR_TIMEOUT_48 (OVR_TIMEOUT_48)
) chk_u (
    .clk_sys, .rst_n, .clock_master_sel, .master_clock_halve, .speed_mode_sel_lo,
    .speed_mode_sel_hi, .rate_family_48k, .overrange_left, .overrange_right,
    .channel_frame_clock_out, .channel_frame_clock_oe, .bit_clock_out, .bit_clock_oe,
    .overflow_out, .overflow_oe
);

//--- tb/sap_rx_model.sv
// audio receiver model: makes slave clocks and deserializes the sample line
`timescale 1ns/1ps
module sap_rx_model (
    input  wire logic                         clk_sys,
    input  wire logic                         rst_n,
    input  wire logic                         drive_clocks,
    input  wire logic                         i2s_mode,
    input  wire logic                         bclk_wire,
    input  wire logic                         frame_wire,
    input  wire logic                         data_wire,
    input  wire logic                         ovf_wire_n,
    output logic                              bclk_drv,
    output logic                              frame_drv,
    output logic [sap_pkg::SAMPLE_W-1:0]      left_word,
    output logic [sap_pkg::SAMPLE_W-1:0]      right_word,
    output logic                              ovf_left_n,
    output logic                              ovf_right_n,
    output int                                n_slots
);
    logic [2:0]  div;
    logic [4:0]  fall_cnt;
    logic        bclk_q;
    logic        lvl_q;
    logic [31:0] slot;
    wire         fall    = bclk_q & ~bclk_wire;
    wire  [31:0] word_in = {slot[30:0], data_wire};
    wire  [23:0] word    = i2s_mode ? word_in[30:7] : word_in[31:8];

    // slave clocks stand still when not asked for; 8-cycle bit clock, 64 per frame
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {div, fall_cnt, bclk_drv, frame_drv} <= '0;
        end else if (drive_clocks) begin
            div <= div + 3'h1;
            if (div == 3'h3) bclk_drv <= 1'b1;
            if (div == 3'h7) begin
                bclk_drv <= 1'b0;
                fall_cnt <= fall_cnt + 5'h1;
                if (fall_cnt == 5'h1f) frame_drv <= ~frame_drv;
            end
        end
    end

    // data launched at one fall is still valid at the next, so sample at falls
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {bclk_q, lvl_q, slot, left_word, right_word, n_slots} <= '0;
            {ovf_left_n, ovf_right_n} <= 2'h3;
        end else begin
            bclk_q <= bclk_wire;
            if (fall) begin
                slot  <= word_in;
                lvl_q <= frame_wire;
                if (frame_wire != lvl_q) begin
                    n_slots <= n_slots + 1;
                    if (lvl_q ^ i2s_mode) left_word <= word;
                    else right_word <= word;
                    if (frame_wire ^ i2s_mode) ovf_right_n <= ovf_wire_n;
                    else ovf_left_n <= ovf_wire_n;
                end
            end
        end
    end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the serial sample output port
`timescale 1ns/1ps
module tb_top;
    import sap_pkg::*;
    localparam int unsigned T441 = 2000;
    localparam int unsigned T48  = 1500;

    logic        clk_sys, rst_n, clock_master_sel, master_clock_halve, offset_filter_enable;
    logic        frame_format_select, speed_mode_sel_lo, speed_mode_sel_hi, rate_family_48k;
    logic        sample_valid, overrange_left, overrange_right, drive_clocks;
    logic        sample_ready, channel_frame_clock_out, channel_frame_clock_oe, bit_clock_out;
    logic        bit_clock_oe, serial_sample_out, overflow_out, overflow_oe;
    logic        bclk_drv, frame_drv, ovf_left_n, ovf_right_n;
    logic [23:0] sample_left, sample_right, left_word, right_word;
    int          n_slots, n_mismatch, total_checks;
    int          cyc = 0;

    // shared pin levels: whoever enables drives, the overflow line has a pull-up
    wire bclk_w  = bit_clock_oe ? bit_clock_out : bclk_drv;
    wire frame_w = channel_frame_clock_oe ? channel_frame_clock_out : frame_drv;
    wire ovf_w_n = overflow_oe ? overflow_out : 1'b1;

    sap_port #(.OVR_TIMEOUT_441(T441), .OVR_TIMEOUT_48(T48), .DEPTH(FIFO_DEPTH)) dut_u (
        .clk_sys, .rst_n, .clock_master_sel, .master_clock_halve, .offset_filter_enable,
        .frame_format_select, .speed_mode_sel_lo, .speed_mode_sel_hi, .rate_family_48k,
        .sample_left, .sample_right, .sample_valid, .sample_ready, .overrange_left,
        .overrange_right, .channel_frame_clock_in(frame_w), .channel_frame_clock_out,
        .channel_frame_clock_oe, .bit_clock_in(bclk_w), .bit_clock_out, .bit_clock_oe,
        .serial_sample_out, .overflow_out, .overflow_oe);

    sap_rx_model rx_u (.clk_sys, .rst_n, .drive_clocks, .i2s_mode(frame_format_select),
        .bclk_wire(bclk_w), .frame_wire(frame_w), .data_wire(serial_sample_out),
        .ovf_wire_n(ovf_w_n), .bclk_drv, .frame_drv, .left_word, .right_word,
        .ovf_left_n, .ovf_right_n, .n_slots);

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    task automatic wait_slots(input int n);
        int goal;
        goal = n_slots + n;
        while (n_slots < goal) tick(1);
    endtask

    // pins change with the master role dropped, so no clock runs mid-change
    task automatic cfg(input logic sel, input logic halve, input logic fmt, input logic [1:0] m);
        clock_master_sel = 1'b0;
        tick(8);
        master_clock_halve = halve;
        frame_format_select = fmt;
        {speed_mode_sel_hi, speed_mode_sel_lo} = m;
        clock_master_sel = sel;
        tick(8);
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        tick(16);
        check({bit_clock_oe, channel_frame_clock_oe, overflow_oe, serial_sample_out}, 4'h0);
        rst_n = 1'b1;
        tick(2);
    endtask

    task automatic t_rates();
        realtime t0;
        int      half;
        for (int m = 0; m < 3; m++) begin
            for (int h = 0; h < 2; h++) begin
                cfg(1'b1, h[0], 1'b0, m[1:0]);
                half = (m == 0 ? 2 : 1) * (h + 1);
                @(posedge bit_clock_out);
                t0 = $realtime;
                @(posedge bit_clock_out);
                check(($realtime - t0) == 50.0 * half, 1'b1);
                @(channel_frame_clock_out);
                t0 = $realtime;
                @(channel_frame_clock_out);
                check(($realtime - t0) == 1600.0 * half, 1'b1);
                tick(1);
            end
        end
        cfg(1'b1, 1'b0, 1'b0, 2'h3);
        check({bit_clock_oe, channel_frame_clock_oe}, 2'h0);
        $display("t_rates done");
    endtask

    task automatic t_master_data();
        sample_left  = 24'h800001;
        sample_right = 24'h7ffffe;
        sample_valid = 1'b1;
        for (int f = 0; f < 2; f++) begin
            cfg(1'b1, 1'b0, f[0], 2'h0);
            wait_slots(12);
            check({left_word, right_word}, {24'h800001, 24'h7ffffe});
        end
        offset_filter_enable = 1'b1;
        wait_slots(16);
        check(left_word == 24'h800001, 1'b0);
        offset_filter_enable = 1'b0;
        sample_valid = 1'b0;
        $display("t_master_data done");
    endtask

    task automatic t_overflow();
        realtime t0;
        for (int f = 0; f < 2; f++) begin
            rate_family_48k = f[0];
            cfg(1'b1, 1'b0, f[0], 2'h0);
            {overrange_left, overrange_right} = f[0] ? 2'h1 : 2'h2;
            t0 = $realtime;
            tick(1);
            {overrange_left, overrange_right} = 2'h0;
            wait_slots(3);
            check({ovf_left_n, ovf_right_n}, 2'h0);
            @(negedge overflow_oe);
            check(($realtime - t0) >= 25.0 * ((f ? T48 : T441) - 1), 1'b1);
            check(($realtime - t0) <= 25.0 * (f ? T48 : T441) + 7000.0, 1'b1);
            wait_slots(3);
            check({ovf_left_n, ovf_right_n}, 2'h3);
        end
        $display("t_overflow done");
    endtask

    // fill the fifo with far clocks still, then drain to silence
    task automatic t_slave_fifo();
        drive_clocks = 1'b0;
        do_reset();
        cfg(1'b0, 1'b0, 1'b1, 2'h1);
        sample_left  = 24'h123456;
        sample_right = 24'hfedcba;
        sample_valid = 1'b1;
        repeat (4) begin
            check(sample_ready, 1'b1);
            tick(1);
        end
        check(sample_ready, 1'b0);
        sample_valid = 1'b0;
        drive_clocks = 1'b1;
        wait_slots(6);
        check({left_word, right_word}, {24'h123456, 24'hfedcba});
        wait_slots(12);
        check({left_word, right_word}, 48'h0);
        check(sample_ready, 1'b1);
        drive_clocks = 1'b0;
        $display("t_slave_fifo done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // cuts a hang short; a clean run needs under half
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            $display("Error at %0t ns: timeout", $time);
            stop_test();
        end
    end

    initial begin
        {clock_master_sel, master_clock_halve, offset_filter_enable, frame_format_select} = '0;
        {speed_mode_sel_lo, speed_mode_sel_hi, rate_family_48k, sample_valid} = '0;
        {overrange_left, overrange_right, drive_clocks, sample_left, sample_right} = '0;
        n_mismatch = 0;
        total_checks = 0;
        do_reset();
        t_rates();
        t_master_data();
        t_overflow();
        t_slave_fifo();
        stop_test();
    end
endmodule
